// >>> logic/amc_pkg.sv
// Purpose: Shared constants and types for the amplifier mode and power control block
// Assumes: Master clock domain at 40 MHz, frame clock as second domain
// Notes: Boot image spans two EEPROM pages
package amc_pkg;
    localparam int BOOT_TOTAL_BYTES = 371;
    localparam int BOOT_PAGE0_BYTES = 256;
    localparam logic [6:0] EE_ADDR_PAGE0 = 7'h50;
    localparam logic [6:0] EE_ADDR_PAGE1 = 7'h51;
    localparam logic [6:0] TGT_ADDR_BASE = 7'h30;
    localparam int TGT_STRAP0_BIT = 2;
    localparam int TGT_STRAP1_BIT = 0;
    localparam int RESET_EXIT_CYCLES = 256;
    localparam int PD_FRAME_LIMIT = 256;
    localparam logic [7:0] VOL_DEFAULT_ON = 8'h31;
    localparam logic [7:0] VOL_MUTED = 8'hFF;
    localparam int SCL_HALF_CYCLES = 50;
    typedef enum logic [1:0] {
        AMC_OUT_RSVD,
        AMC_OUT_2P1,
        AMC_OUT_STEREO,
        AMC_OUT_MONO
    } amc_out_mode_t;
endpackage

// >>> logic/amc_sync.sv
// Purpose: Two flop synchroniser for one level
// Assumes: Destination clock is clk
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module amc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } amc_sync_st_t;
    amc_sync_st_t st_reg;
    amc_sync_st_t st_next;
    always_comb begin
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign sync_out = st_reg.s2;
endmodule

// >>> logic/amc_frame_cnt.sv
// Purpose: Counts frame clock edges while power down is requested
// Assumes: Frame clock runs during fade; request arrives synchronised to the master clock and is not resynchronised here
// Notes: Count leaves as a toggle so the master domain sees each frame
`timescale 1ns/100ps
module amc_frame_cnt (
    input wire logic frame_clock_in,
    input wire logic frame_rst,
    output logic frame_toggle
);
    typedef struct packed {
        logic tog;
    } amc_fc_st_t;
    amc_fc_st_t st_reg;
    amc_fc_st_t st_next;
    always_comb begin
        st_next.tog = ~st_reg.tog;
    end
    always_ff @(posedge frame_clock_in) begin
        if (frame_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign frame_toggle = st_reg.tog;
endmodule

// >>> logic/amc_top.sv
// Purpose: Mode straps, boot load, reset release, power down and fault control
// Assumes: sys_rst is a synchronous reset; pins are asynchronous and synchronised
// Notes: Audio path and register map live elsewhere; this block steers them
// Functional notes
// RL1: Defaults apply when no host programs
// RL2: PLL pin high bypasses internal PLL
// RL3: Boot volume strap sets default volume
// RL4: Hostless systems tie volume strap high
// RL5: Source strap picks serial input a/b
// RL6: Host mutes before switching source strap
// RL7: EEPROM strap high: boot load, then target
// RL8: EEPROM strap low: never start transfers
// RL9: Boot image is 371 bytes
// RL10: First 256 bytes page0, rest page1
// RL11: Reset pin low clears all settings
// RL12: Leave reset on 256th clock after release
// RL13: Power down fades, gates, within 256 frames
// RL14: Powered down ignores writes, keeps settings
// RL15: Power down released mid-fade fades back in
// RL16: Fault disables outputs, latches error low
// RL17: Error clears on reset, powerdown or mute
// RL18: Undervoltage stops stages until supply recovers
// RL19: Config pins select output mode
// RL20: Host unmutes after system is stable
// RL21: Line driver enabled 2ms after supply
// RL22: Target address is 0110x0y from straps
// RL23: Boot load uses proper I2C read sequences
`timescale 1ns/100ps
module amc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frame_clock_in,
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic pll_bypass_pin,
    input wire logic boot_volume_select,
    input wire logic audio_source_select,
    input wire logic eeprom_boot_select,
    input wire logic output_config_low,
    input wire logic output_config_high,
    input wire logic address_strap_0,
    input wire logic address_strap_1,
    input wire logic serial_audio_in_a,
    input wire logic serial_audio_in_b,
    input wire logic over_temp,
    input wire logic short_detect,
    input wire logic core_supply_low,
    input wire logic core_supply_ok,
    input wire logic host_mute_write,
    input wire logic host_write_req,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    output logic serial_audio_sel,
    output logic pll_bypass,
    output logic [7:0] default_volume,
    output logic [1:0] output_mode,
    output logic [6:0] target_address,
    output logic target_enable,
    output logic host_write_accept,
    output logic clear_settings,
    output logic boot_wr_valid,
    output logic [8:0] boot_wr_index,
    output logic [7:0] boot_wr_data,
    output logic boot_done,
    output logic in_reset,
    output logic fade_down,
    output logic power_stage_en,
    output logic clock_gate_en,
    output logic analog_bias_en,
    output logic power_down_state,
    output logic error_out,
    output logic error_oe_n
);
    typedef enum logic [2:0] {
        RST_HOLD, BOOT, RUN, FADE_OUT, PD_STATE, FADE_IN
    } amc_state_t;
    typedef enum logic [2:0] {
        I_IDLE, I_START, I_BIT, I_ACK, I_RESTART, I_STOP
    } amc_i2c_t;
    typedef struct packed {
        amc_state_t st;
        logic [8:0] rcnt;
        logic [8:0] fcnt;
        logic ftog_d;
        logic err;
        amc_i2c_t ist;
        logic [6:0] sclc;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [1:0] step;
        logic page;
        logic [8:0] idx;
        logic scl;
        logic sda;
        logic wv;
        logic [7:0] wd;
        logic [7:0] vol;
        logic [1:0] mode;
        logic [6:0] taddr;
        logic byp;
        logic uv;
    } amc_st_t;
    amc_st_t st_reg;
    amc_st_t st_next;
    logic rst_n_s, pd_n_s, pll_s, vol_s, src_s, ms_s, c0_s, c1_s, a0_s, a1_s;
    logic ot_s, sc_s, uvl_s, uvok_s, sda_s, ftog, ftog_s, frame_rst;
    logic [15:0] pin_raw, pin_sync;
    assign pin_raw = {reset_n, power_down_n, pll_bypass_pin, boot_volume_select,
        audio_source_select, eeprom_boot_select, output_config_low, output_config_high,
        address_strap_0, address_strap_1, over_temp, short_detect, core_supply_low,
        core_supply_ok, sda_in, ftog};
    assign {rst_n_s, pd_n_s, pll_s, vol_s, src_s, ms_s, c0_s, c1_s, a0_s, a1_s,
        ot_s, sc_s, uvl_s, uvok_s, sda_s, ftog_s} = pin_sync;
    for (genvar g = 0; g < 16; g++) begin : g_sync
        amc_sync u_s (.clk(clk), .sys_rst(sys_rst), .async_in(pin_raw[g]),
            .sync_out(pin_sync[g]));
    end

    // Frame counter runs only while power down is requested (fade out and power down state)
    assign frame_rst = pd_n_s;
    amc_frame_cnt u_fc (.frame_clock_in(frame_clock_in), .frame_rst(frame_rst),
        .frame_toggle(ftog));

    always_comb begin
        st_next = st_reg;
        st_next.wv = 1'b0;
        st_next.ftog_d = ftog_s;
        // Hysteresis between the two supply thresholds
        if (uvl_s) begin
            st_next.uv = 1'b1; // RL18
        end else if (uvok_s) begin
            st_next.uv = 1'b0; // RL18
        end
        if (ot_s || sc_s) begin
            st_next.err = 1'b1; // RL16
        end else if (!rst_n_s || !pd_n_s || host_mute_write) begin
            st_next.err = 1'b0; // RL17
        end
        if (!rst_n_s) begin
            st_next.st = RST_HOLD; // RL11
            st_next.rcnt = '0;
            st_next.ist = I_IDLE;
            st_next.scl = 1'b1;
            st_next.sda = 1'b1;
        end else begin
            case (st_reg.st)
                RST_HOLD: begin
                    st_next.rcnt = st_reg.rcnt + 9'h001;
                    // Straps are caught while leaving reset
                    st_next.vol = vol_s ? amc_pkg::VOL_DEFAULT_ON : amc_pkg::VOL_MUTED; // RL3
                    st_next.mode = {c1_s, c0_s}; // RL19
                    st_next.byp = pll_s; // RL2
                    st_next.taddr = amc_pkg::TGT_ADDR_BASE
                        | {4'h0, a0_s, 1'b0, a1_s}; // RL22
                    if (st_reg.rcnt == 9'(amc_pkg::RESET_EXIT_CYCLES - 1)) begin
                        st_next.st = ms_s ? BOOT : RUN; // RL7 RL8 RL12
                        st_next.ist = I_START;
                        st_next.step = 2'h0;
                        st_next.page = 1'b0;
                        st_next.idx = '0;
                        st_next.sclc = '0;
                        st_next.ph = 2'h0;
                    end
                end
                BOOT: begin
                    st_next.sclc = st_reg.sclc + 7'h01;
                    if (st_reg.sclc == 7'(amc_pkg::SCL_HALF_CYCLES - 1)) begin
                        st_next.sclc = '0;
                        st_next.ph = st_reg.ph + 2'h1;
                        // RL23: four phases per bit, data changes with SCL low
                        case (st_reg.ist)
                            I_START: begin
                                if (st_reg.ph == 2'h0) begin
                                    st_next.sda = 1'b1;
                                    st_next.scl = 1'b1;
                                end else if (st_reg.ph == 2'h1) begin
                                    st_next.sda = 1'b0;
                                end else if (st_reg.ph == 2'h3) begin
                                    st_next.scl = 1'b0;
                                    st_next.ist = I_BIT;
                                    st_next.bitn = 4'h0;
                                    // Read bit only after the repeated start
                                    st_next.sh = {st_reg.page ? amc_pkg::EE_ADDR_PAGE1
                                        : amc_pkg::EE_ADDR_PAGE0, st_reg.step != 2'h0}; // RL10
                                end
                            end
                            I_BIT: begin
                                if (st_reg.ph == 2'h0) begin
                                    st_next.sda = (st_reg.step == 2'h3) ? 1'b1 : st_reg.sh[7];
                                end else if (st_reg.ph == 2'h1) begin
                                    st_next.scl = 1'b1;
                                end else if (st_reg.ph == 2'h2) begin
                                    st_next.sh = {st_reg.sh[6:0], sda_s};
                                end else begin
                                    st_next.scl = 1'b0;
                                    st_next.bitn = st_reg.bitn + 4'h1;
                                    if (st_reg.bitn == 4'h7) begin
                                        st_next.ist = I_ACK;
                                    end
                                end
                            end
                            I_ACK: begin
                                if (st_reg.ph == 2'h0) begin
                                    // Master acks data except the last of a page
                                    st_next.sda = (st_reg.step == 2'h3) ?
                                        (st_reg.idx == 9'(amc_pkg::BOOT_PAGE0_BYTES - 1)
                                        || st_reg.idx == 9'(amc_pkg::BOOT_TOTAL_BYTES - 1))
                                        : 1'b1;
                                end else if (st_reg.ph == 2'h1) begin
                                    st_next.scl = 1'b1;
                                end else if (st_reg.ph == 2'h3) begin
                                    st_next.scl = 1'b0;
                                    st_next.bitn = 4'h0;
                                    st_next.ist = I_BIT;
                                    if (st_reg.step == 2'h0) begin
                                        st_next.step = 2'h1;
                                        st_next.sh = 8'h00;
                                    end else if (st_reg.step == 2'h1) begin
                                        st_next.step = 2'h2;
                                        st_next.ist = I_RESTART;
                                    end else if (st_reg.step == 2'h2) begin
                                        st_next.step = 2'h3;
                                    end else begin
                                        st_next.wv = 1'b1;
                                        st_next.wd = st_reg.sh;
                                        st_next.idx = st_reg.idx + 9'h001;
                                        if (st_reg.idx == 9'(amc_pkg::BOOT_PAGE0_BYTES - 1)
                                            || st_reg.idx
                                            == 9'(amc_pkg::BOOT_TOTAL_BYTES - 1)) begin
                                            st_next.ist = I_STOP; // RL9
                                        end
                                    end
                                end
                            end
                            I_RESTART: begin
                                st_next.ist = I_START;
                                st_next.ph = 2'h0;
                            end
                            I_STOP: begin
                                if (st_reg.ph == 2'h0) begin
                                    st_next.sda = 1'b0;
                                end else if (st_reg.ph == 2'h1) begin
                                    st_next.scl = 1'b1;
                                end else if (st_reg.ph == 2'h2) begin
                                    st_next.sda = 1'b1;
                                end else begin
                                    st_next.step = 2'h0;
                                    if (st_reg.page) begin
                                        st_next.ist = I_IDLE;
                                        st_next.st = RUN; // RL7
                                    end else begin
                                        st_next.page = 1'b1;
                                        st_next.ist = I_START;
                                    end
                                end
                            end
                            default: st_next.ist = I_IDLE;
                        endcase
                    end
                end
                RUN: begin
                    if (!pd_n_s) begin
                        st_next.st = FADE_OUT; // RL13
                        st_next.fcnt = '0;
                    end
                end
                FADE_OUT: begin
                    if (ftog_s != st_reg.ftog_d) begin
                        st_next.fcnt = st_reg.fcnt + 9'h001;
                    end
                    if (pd_n_s) begin
                        st_next.st = FADE_IN; // RL15
                        st_next.fcnt = '0;
                    end else if (st_reg.fcnt == 9'(amc_pkg::PD_FRAME_LIMIT - 1)) begin
                        st_next.st = PD_STATE; // RL13
                    end
                end
                PD_STATE: begin
                    if (pd_n_s) begin
                        st_next.st = FADE_IN;
                        st_next.fcnt = '0;
                    end
                end
                FADE_IN: begin
                    st_next.fcnt = st_reg.fcnt + 9'h001;
                    if (!pd_n_s) begin
                        st_next.st = FADE_OUT;
                        st_next.fcnt = '0;
                    end else if (st_reg.fcnt == 9'(amc_pkg::PD_FRAME_LIMIT - 1)) begin
                        st_next.st = RUN;
                    end
                end
                default: st_next.st = RST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{st: RST_HOLD, ist: I_IDLE, scl: 1'b1, sda: 1'b1,
                vol: amc_pkg::VOL_MUTED, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    logic active;
    assign active = (st_reg.st == RUN) || (st_reg.st == FADE_IN) || (st_reg.st == FADE_OUT);
    assign in_reset = (st_reg.st == RST_HOLD);
    assign clear_settings = !rst_n_s; // RL11
    assign pll_bypass = st_reg.byp; // RL2
    assign default_volume = st_reg.vol; // RL1 RL3
    assign output_mode = st_reg.mode; // RL19
    assign target_address = st_reg.taddr; // RL22
    // Target stays silent while the boot load owns the bus
    assign target_enable = (st_reg.st != RST_HOLD) && (st_reg.st != BOOT); // RL7
    assign host_write_accept = host_write_req && target_enable
        && (st_reg.st != PD_STATE); // RL14
    assign serial_audio_sel = src_s; // RL5
    // Open drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = !((st_reg.st == BOOT) && !st_reg.scl); // RL8
    assign sda_oe_n = !((st_reg.st == BOOT) && !st_reg.sda); // RL8
    assign boot_wr_valid = st_reg.wv;
    assign boot_wr_index = st_reg.idx - 9'h001;
    assign boot_wr_data = st_reg.wd;
    assign boot_done = (st_reg.st != RST_HOLD) && (st_reg.st != BOOT);
    assign fade_down = (st_reg.st == FADE_OUT) || (st_reg.st == PD_STATE); // RL13
    assign power_stage_en = active && !st_reg.err && !st_reg.uv; // RL16 RL18
    assign clock_gate_en = (st_reg.st != PD_STATE) && !st_reg.uv; // RL13 RL18
    assign analog_bias_en = (st_reg.st != PD_STATE); // RL13
    assign power_down_state = (st_reg.st == PD_STATE); // RL14
    assign error_out = 1'b0;
    assign error_oe_n = !st_reg.err; // RL16
endmodule

// >>> bench/amc_top_assertions.sv
// Purpose: Port timing relations of amc_top
// Assumes: Straps change only while the reset pin is low
// Notes: Fade bound allows 256 frames of 5 master cycles plus sync slack
`timescale 1ns/100ps
module amc_top_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic eeprom_boot_select,
    input wire logic output_config_low,
    input wire logic output_config_high,
    input wire logic address_strap_0,
    input wire logic address_strap_1,
    input wire logic over_temp,
    input wire logic short_detect,
    input wire logic host_write_req,
    input wire logic scl_oe_n,
    input wire logic [1:0] output_mode,
    input wire logic [6:0] target_address,
    input wire logic host_write_accept,
    input wire logic clear_settings,
    input wire logic boot_wr_valid,
    input wire logic [8:0] boot_wr_index,
    input wire logic in_reset,
    input wire logic fade_down,
    input wire logic power_stage_en,
    input wire logic clock_gate_en,
    input wire logic analog_bias_en,
    input wire logic power_down_state,
    input wire logic error_oe_n
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [9:0] rcnt_reg;
    logic [10:0] fcnt_reg;
    logic [8:0] nidx_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || !reset_n) rcnt_reg <= 10'h000;
        else if (rcnt_reg != 10'h3FF) rcnt_reg <= rcnt_reg + 10'h001;
        if (!fade_down || power_down_state) fcnt_reg <= 11'h000;
        else fcnt_reg <= fcnt_reg + 11'h001;
        if (in_reset) nidx_reg <= 9'h000;
        else if (boot_wr_valid) nidx_reg <= nidx_reg + 9'h001;
    end
    reset_exit_a: assert property ($fell(in_reset) |-> rcnt_reg >= 10'h100 && rcnt_reg <= 10'h106)
        else $error("reset left at wrong cycle");
    clear_hold_a: assert property (!reset_n [*4] |-> clear_settings)
        else $error("settings not cleared in reset");
    write_refuse_a: assert property (host_write_accept |-> host_write_req && !in_reset && !power_down_state)
        else $error("write taken when refused");
    master_idle_a: assert property (!eeprom_boot_select |-> scl_oe_n)
        else $error("clock driven without boot strap");
    boot_order_a: assert property (boot_wr_valid |-> boot_wr_index == nidx_reg && boot_wr_index <= 9'h172)
        else $error("boot byte out of order");
    fade_bound_a: assert property (fcnt_reg <= 11'h514)
        else $error("fade out too long");
    pd_gate_a: assert property (power_down_state |-> !power_stage_en && !clock_gate_en && !analog_bias_en)
        else $error("power down left something on");
    fault_latch_a: assert property ((over_temp || short_detect) [*5] |-> !error_oe_n && !power_stage_en)
        else $error("fault not latched");
    strap_load_a: assert property ($fell(in_reset) |=> output_mode == {output_config_high, output_config_low}
        && target_address == {4'h6, address_strap_0, 1'h0, address_strap_1})
        else $error("strap outputs wrong");
endmodule
bind amc_top amc_top_chk chk_u (.*);

// >>> bench/amc_eeprom_model.sv
// Purpose: Behavioural serial boot memory on the two-wire bus
// Assumes: Both lines pulled up; sda_drv low pulls data low
// Notes: Byte image is a fixed pattern of the 9-bit index
`timescale 1ns/100ps
module amc_eeprom_model (
    input wire logic scl,
    input wire logic sda,
    output logic sda_drv
);
    logic [7:0] sh, dout, ptr;
    logic act = 1'b0, rd = 1'b0, page = 1'b0;
    int bitn, byten;
    initial sda_drv = 1'b1;
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        bitn = 0;
        byten = 0;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    always @(posedge scl) if (act) begin
        sh = {sh[6:0], sda};
        bitn++;
    end
    always @(negedge scl) if (act) begin
        sda_drv = 1'b1;
        if (bitn == 8 && (byten == 0 || !rd)) begin
            if (byten == 0) begin
                rd = sh[0];
                page = sh[1];
            end else ptr = sh;
            sda_drv = byten == 0 && sh[7:2] != 6'h28;
        end else if (bitn == 9) begin
            bitn = 0;
            byten++;
            // A refused byte ends the read so the stop can pass
            if (rd && sh[0] && byten > 1) act = 1'b0;
            else if (rd) begin
                dout = 8'hA5 ^ ptr ^ {page, 7'h00};
                ptr++;
                sda_drv = dout[7];
            end
        end else if (rd && byten > 0 && bitn < 8) sda_drv = dout[7 - bitn];
    end
endmodule

// >>> bench/tb_amc_top.sv
// Purpose: Self-checking bench for amc_top
// Assumes: Strap pins change only while the reset pin is low
// Notes: Boot load is checked on its first bytes only, to keep the run short
`timescale 1ns/100ps
module tb_amc_top;
    logic clk = 1'b0, sys_rst = 1'b1, frame_clock_in = 1'b0, reset_n = 1'b0, power_down_n = 1'b1;
    logic pll_bypass_pin = 1'b0, boot_volume_select = 1'b1, audio_source_select = 1'b0;
    logic eeprom_boot_select = 1'b0, output_config_low = 1'b1, output_config_high = 1'b0;
    logic address_strap_0 = 1'b0, address_strap_1 = 1'b0, serial_audio_in_a = 1'b0;
    logic serial_audio_in_b = 1'b0, over_temp = 1'b0, short_detect = 1'b0, core_supply_low = 1'b0;
    logic core_supply_ok = 1'b1, host_mute_write = 1'b0, host_write_req = 1'b0, ee_drv;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, serial_audio_sel, pll_bypass, target_enable;
    logic host_write_accept, clear_settings, boot_wr_valid, boot_done, in_reset, fade_down;
    logic power_stage_en, clock_gate_en, analog_bias_en, power_down_state, error_out, error_oe_n;
    logic [7:0] default_volume, boot_wr_data;
    logic [1:0] output_mode;
    logic [6:0] target_address;
    logic [8:0] boot_wr_index;
    wire scl_in = scl_oe_n;
    wire sda_in = sda_oe_n & ee_drv;
    int fails = 0, n_tests = 0;
    amc_top dut_u (.*);
    amc_eeprom_model ee_u (.scl(scl_in), .sda(sda_in), .sda_drv(ee_drv));
    initial forever #12.5 clk = ~clk;
    initial begin
        #7;
        forever #62.5 frame_clock_in = ~frame_clock_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pin_reset(input logic [7:0] s);
        int k;
        reset_n = 1'b0;
        cyc(8);
        chk("clear", 16'h1, clear_settings);
        {eeprom_boot_select, pll_bypass_pin, boot_volume_select, output_config_high,
            output_config_low, address_strap_0, address_strap_1, audio_source_select} = s;
        cyc(4);
        reset_n = 1'b1;
        for (k = 0; k < 400 && in_reset !== 1'b0; k++) cyc(1);
        chk("exit", 16'h1, k >= 256 && k <= 262);
    endtask
    task automatic t_straps();
        logic [7:0] tab [4] = '{8'h61, 8'h53, 8'h1E, 8'h2C};
        foreach (tab[i]) begin
            pin_reset(tab[i]);
            cyc(4);
            chk("mode", tab[i][4:3], output_mode);
            chk("pll", tab[i][6], pll_bypass);
            chk("vol", tab[i][5] ? amc_pkg::VOL_DEFAULT_ON : amc_pkg::VOL_MUTED, default_volume);
            chk("addr", {4'h6, tab[i][2], 1'h0, tab[i][1]}, target_address);
            chk("src", tab[i][0], serial_audio_sel);
        end
    endtask
    task automatic t_power_down();
        int k;
        power_down_n = 1'b0;
        for (k = 0; k < 1500 && power_down_state !== 1'b1; k++) cyc(1);
        chk("pd_time", 16'h1, k <= 1300);
        host_write_req = 1'b1;
        cyc(1);
        chk("pd_off", 16'h0, {power_stage_en, clock_gate_en, analog_bias_en, host_write_accept});
        power_down_n = 1'b1;
        for (k = 0; k < 800 && power_stage_en !== 1'b1; k++) cyc(1);
        chk("pd_keep", 16'h1, output_mode);
        chk("wr_run", 16'h1, host_write_accept);
        host_write_req = 1'b0;
        power_down_n = 1'b0;
        cyc(200);
        chk("fading", 16'h1, fade_down);
        power_down_n = 1'b1;
        for (k = 0; k < 800 && fade_down !== 1'b0; k++) cyc(1);
        cyc(300);
        chk("fade_in", 16'h7, {power_stage_en, clock_gate_en, analog_bias_en});
    endtask
    task automatic mute_pulse();
        host_mute_write = 1'b1;
        cyc(1);
        host_mute_write = 1'b0;
        cyc(3);
    endtask
    task automatic t_fault(input logic kind);
        {over_temp, short_detect} = kind ? 2'b01 : 2'b10;
        cyc(6);
        chk("err_set", 16'h0, {error_out, error_oe_n, power_stage_en});
        mute_pulse();
        chk("err_wins", 16'h0, error_oe_n);
        {over_temp, short_detect} = 2'b00;
        cyc(20);
        chk("err_hold", 16'h0, error_oe_n);
        mute_pulse();
        chk("err_clr", 16'h1, error_oe_n);
    endtask
    task automatic t_undervolt();
        {core_supply_low, core_supply_ok} = 2'b10;
        cyc(6);
        chk("uv_off", 16'h0, power_stage_en);
        core_supply_low = 1'b0;
        cyc(6);
        chk("uv_hyst", 16'h0, power_stage_en);
        core_supply_ok = 1'b1;
        cyc(6);
        chk("uv_on", 16'h1, power_stage_en);
    endtask
    task automatic t_boot();
        int k;
        pin_reset(8'hAC);
        host_write_req = 1'b1;
        cyc(2);
        chk("boot_busy", 16'h0, {target_enable, host_write_accept});
        host_write_req = 1'b0;
        for (int i = 0; i < 4; i++) begin
            for (k = 0; k < 8000 && boot_wr_valid !== 1'b1; k++) cyc(1);
            chk("b_idx", 16'(i), boot_wr_index);
            chk("b_data", 16'(8'hA5 ^ 8'(i)), boot_wr_data);
            cyc(1);
        end
        pin_reset(8'h2C);
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(40000 * 25);
        fails++;
        print_verdict();
    end
    initial begin
        cyc(4);
        sys_rst = 1'b0;
        t_straps();
        t_power_down();
        t_fault(1'b0);
        t_fault(1'b1);
        t_undervolt();
        t_boot();
        print_verdict();
    end
endmodule
